// File: hw/lsr_ctrl.v
/*
 * Host controller for a latched-address 2K x 8 static memory. Takes one read
 * or write request at a time and sequences chip_on_n, store_n, out_drive_n,
 * address and data pins with grade-correct minimum intervals.
 * Assumes inputs synchronous to core_clk (250 MHz) and a memory that behaves
 * as its timing table promises.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lsr_ctrl_map.vh"

// Operation
// RULE1 - memory holds 2048 bytes at 11-bit addresses; host addresses all of them
// RULE2 - address stable no later than chip_on_n falling edge; memory latches it
// RULE3 - address may change only after hold interval past the falling edge
// RULE4 - read data valid by access time after chip_on_n falls
// RULE5 - store_n stays high throughout every read cycle
// RULE6 - memory releases data bus within off time after chip_on_n rises
// RULE7 - out_drive_n high keeps memory outputs off; valid 80 ns after low
// RULE8 - write cycle begins, and address latches, on chip_on_n falling edge
// RULE9 - host may keep out_drive_n high across a write cycle
// RULE10 - write data stable setup time before ending edge until 10 ns after
// RULE11 - never let chip_on_n and out_drive_n both fall before store_n
// RULE12 - if chip_on_n rises first, data timing references its rising edge
// RULE13 - write commits at first rising edge of store_n or chip_on_n
// RULE14 - chip_on_n stays high at least the minimum before next cycle
// RULE15 - store_n may stay low across back-to-back writes, one location each
// RULE16 - with store_n held low, data timing references each chip_on_n rise
// RULE17 - successive chip_on_n falling edges spaced at least the cycle time
// RULE18 - chip_on_n held low at least the minimum pulse width
// RULE19 - store_n held low at least the minimum write pulse width
// RULE20 - store_n falling with outputs on turns them off within off time
// RULE21 - data bus modelled as in lane, out lane and enable flag
module lsr_ctrl #(
    parameter SLOW_GRADE = 0,
    parameter ADDR_W = `LSR_ADDR_W,
    parameter DATA_W = `LSR_DATA_W
) (
    input wire core_clk,
    input wire resetn,
    input wire reqValid,
    input wire reqWrite,
    input wire reqBurst,
    input wire [ADDR_W-1:0] reqAddr,
    input wire [DATA_W-1:0] reqWdata,
    output reg reqReady,
    output reg rspValid,
    output reg [DATA_W-1:0] rspRdata,
    output reg chipOnN,
    output reg storeN,
    output reg outDriveN,
    output reg [ADDR_W-1:0] memAddr,
    output reg [DATA_W-1:0] memDataOut,
    output reg memDataOeN,
    input wire [DATA_W-1:0] memDataIn
);
    // ======================================================
    // cycle counts; minimums round up
    localparam integer P = `LSR_CLK_PERIOD_NS;
    localparam integer HOLD_NS = SLOW_GRADE ? `LSR_S_ADDR_HOLD_NS : `LSR_F_ADDR_HOLD_NS;
    localparam integer ACC_NS = SLOW_GRADE ? `LSR_S_ACCESS_NS : `LSR_F_ACCESS_NS;
    localparam integer ELOW_NS = SLOW_GRADE ? `LSR_S_E_LOW_NS : `LSR_F_E_LOW_NS;
    localparam integer EHIGH_NS = SLOW_GRADE ? `LSR_S_E_HIGH_NS : `LSR_F_E_HIGH_NS;
    localparam integer WLOW_NS = SLOW_GRADE ? `LSR_S_W_LOW_NS : `LSR_F_W_LOW_NS;
    localparam integer DSU_NS = SLOW_GRADE ? `LSR_S_DSETUP_NS : `LSR_F_DSETUP_NS;
    localparam integer CYC_NS = SLOW_GRADE ? `LSR_S_CYCLE_NS : `LSR_F_CYCLE_NS;
    localparam integer OFF_NS = SLOW_GRADE ? `LSR_S_OFF_NS : `LSR_F_OFF_NS;
    localparam integer HOLD_CYC = (HOLD_NS + P - 1) / P;
    localparam integer ELOW_RAW = (ELOW_NS + P - 1) / P;
    localparam integer WLOW_CYC = (WLOW_NS + P - 1) / P;
    localparam integer DSU_CYC = (DSU_NS + P - 1) / P;
    localparam integer VAL_CYC = (`LSR_G_VALID_NS + P - 1) / P;
    localparam integer ACC_CYC = (ACC_NS + P - 1) / P;
    // read needs the slower of address access and output-drive valid, plus one for the sample
    localparam integer RD_RAW = ((ACC_CYC > VAL_CYC + 1) ? ACC_CYC : VAL_CYC + 1) + 1;
    localparam integer LOW1 = (ELOW_RAW > RD_RAW) ? ELOW_RAW : RD_RAW;
    localparam integer LOW2 = (LOW1 > WLOW_CYC) ? LOW1 : WLOW_CYC;
    localparam integer LOW_CYC = (LOW2 > DSU_CYC) ? LOW2 : DSU_CYC;
    localparam integer DH_CYC = (`LSR_DHOLD_NS + P - 1) / P;
    localparam integer OFF_CYC = (OFF_NS + P - 1) / P;
    localparam integer EH1 = (EHIGH_NS + P - 1) / P;
    localparam integer EH2 = (EH1 > OFF_CYC) ? EH1 : OFF_CYC;
    localparam integer EH3 = (EH2 > DH_CYC) ? EH2 : DH_CYC;
    // high time also pads the falling-edge spacing up to the full cycle time
    localparam integer CYC_CYC = (CYC_NS + P - 1) / P;
    localparam integer HIGH_CYC = (CYC_CYC - LOW_CYC - 1 > EH3) ? CYC_CYC - LOW_CYC - 1 : EH3;
    localparam integer TW = 8;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg isWrite_r;
    reg burst_r;
    reg [ADDR_W-1:0] holdAddr_r;
    reg [DATA_W-1:0] holdData_r;
    reg tLoad;
    reg [TW-1:0] tValue;
    reg [TW-1:0] holdCount_r;
    wire tDone;

    lsr_ctrl_timer #(
        .W(TW)
    ) u_timer (
        .core_clk(core_clk),
        .resetn(resetn),
        .load(tLoad),
        .loadValue(tValue),
        .done(tDone)
    );

    // ======================================================
    // next state
    always @* begin
        state_nxt = state_r;
        tLoad = 1'b0;
        tValue = {TW{1'b0}};
        case (state_r)
            `LSR_ST_IDLE: begin
                if (reqValid) begin
                    state_nxt = `LSR_ST_SETUP;
                end
            end
            `LSR_ST_SETUP: begin
                // address and store_n settled one cycle ahead of the falling edge
                state_nxt = `LSR_ST_LOW;
                tLoad = 1'b1;
                tValue = LOW_CYC[TW-1:0] - 8'h01;
            end
            `LSR_ST_LOW: begin
                if (tDone) begin
                    state_nxt = `LSR_ST_HIGH;
                    tLoad = 1'b1;
                    tValue = HIGH_CYC[TW-1:0] - 8'h01;
                end
            end
            `LSR_ST_HIGH: begin
                if (tDone) begin
                    state_nxt = `LSR_ST_IDLE;
                end
            end
            default: begin
                state_nxt = `LSR_ST_IDLE;
            end
        endcase
    end

    // ======================================================
    // pins and handshake
    always @(posedge core_clk) begin
        if (!resetn) begin
            state_r <= `LSR_ST_IDLE;
            isWrite_r <= 1'b0;
            burst_r <= 1'b0;
            holdAddr_r <= {ADDR_W{1'b0}};
            holdData_r <= {DATA_W{1'b0}};
            holdCount_r <= {TW{1'b0}};
            reqReady <= 1'b0;
            rspValid <= 1'b0;
            rspRdata <= {DATA_W{1'b0}};
            chipOnN <= 1'b1;
            storeN <= 1'b1;
            outDriveN <= 1'b1;
            memAddr <= {ADDR_W{1'b0}};
            memDataOut <= {DATA_W{1'b0}};
            memDataOeN <= 1'b1;
        end else begin
            state_r <= state_nxt;
            rspValid <= 1'b0;
            reqReady <= (state_nxt == `LSR_ST_IDLE);
            if (holdCount_r != {TW{1'b0}}) begin
                holdCount_r <= holdCount_r - 8'h01;
            end
            case (state_r)
                `LSR_ST_IDLE: begin
                    if (reqValid) begin
                        reqReady <= 1'b0;
                        isWrite_r <= reqWrite;
                        burst_r <= reqWrite & reqBurst;
                        holdAddr_r <= reqAddr;
                        holdData_r <= reqWdata;
                        memAddr <= reqAddr; // RULE1 RULE2
                        if (reqWrite) begin
                            storeN <= 1'b0; // RULE11 RULE15
                            memDataOut <= reqWdata;
                            memDataOeN <= 1'b0; // RULE21
                            outDriveN <= 1'b1; // RULE9 RULE20
                        end else begin
                            storeN <= 1'b1; // RULE5
                            memDataOeN <= 1'b1; // RULE21
                        end
                    end else if (!burst_r) begin
                        storeN <= 1'b1;
                    end
                end
                `LSR_ST_SETUP: begin
                    chipOnN <= 1'b0; // RULE8 RULE2
                    holdCount_r <= HOLD_CYC[TW-1:0]; // RULE3
                    if (!isWrite_r) begin
                        outDriveN <= 1'b0; // RULE7
                    end
                end
                `LSR_ST_LOW: begin
                    // address held at least the hold interval past the fall
                    if (holdCount_r == {TW{1'b0}}) begin
                        memAddr <= holdAddr_r; // RULE3
                    end
                    if (tDone) begin
                        // write ends on chip_on_n rising; data held through high phase
                        chipOnN <= 1'b1; // RULE13 RULE12 RULE16 RULE18 RULE19
                        outDriveN <= 1'b1; // RULE6
                        if (!isWrite_r) begin
                            rspRdata <= memDataIn; // RULE4
                        end
                        if (!burst_r) begin
                            storeN <= 1'b1;
                        end
                    end
                end
                `LSR_ST_HIGH: begin
                    // keep driving write data for its hold, then release
                    memDataOut <= holdData_r; // RULE10
                    if (tDone) begin
                        memDataOeN <= 1'b1; // RULE14 RULE17
                        rspValid <= 1'b1;
                    end
                end
                default: begin
                    chipOnN <= 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: hw/lsr_ctrl_map.vh
/*
 * Constants for the host-side controller of the latched 2K x 8 static memory:
 * geometry, grade-dependent timing figures in ns, state codes.
 * Assumes a 250 MHz core clock; the cycle counts are derived in the controller.
 */
`ifndef LSR_CTRL_MAP_VH
`define LSR_CTRL_MAP_VH

// ==========================================================
// geometry
`define LSR_ADDR_W 11
`define LSR_DATA_W 8
`define LSR_WORDS 2048

// ==========================================================
// clock
`define LSR_CLK_PERIOD_NS 4

// ==========================================================
// timing, fast grade (ns)
`define LSR_F_ADDR_HOLD_NS 30
`define LSR_F_ACCESS_NS 120
`define LSR_F_E_LOW_NS 120
`define LSR_F_E_HIGH_NS 50
`define LSR_F_W_LOW_NS 120
`define LSR_F_DSETUP_NS 50
`define LSR_F_CYCLE_NS 170
`define LSR_F_OFF_NS 50

// ==========================================================
// timing, slow grade (ns)
`define LSR_S_ADDR_HOLD_NS 50
`define LSR_S_ACCESS_NS 200
`define LSR_S_E_LOW_NS 200
`define LSR_S_E_HIGH_NS 80
`define LSR_S_W_LOW_NS 200
`define LSR_S_DSETUP_NS 80
`define LSR_S_CYCLE_NS 280
`define LSR_S_OFF_NS 80

// ==========================================================
// grade independent (ns)
`define LSR_G_VALID_NS 80
`define LSR_DHOLD_NS 10

// ==========================================================
// states
`define LSR_ST_IDLE 3'h0
`define LSR_ST_SETUP 3'h1
`define LSR_ST_LOW 3'h2
`define LSR_ST_HOLD 3'h3
`define LSR_ST_HIGH 3'h4

`endif

// File: hw/lsr_ctrl_timer.v
/*
 * Down counter used to time strobe intervals of the memory cycle.
 * Assumes load and loadValue inputs synchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module lsr_ctrl_timer #(
    parameter W = 8
) (
    input wire core_clk,
    input wire resetn,
    input wire load,
    input wire [W-1:0] loadValue,
    output wire done
);
    reg [W-1:0] count_r;

    always @(posedge core_clk) begin
        if (!resetn) begin
            count_r <= {W{1'b0}};
        end else if (load) begin
            count_r <= loadValue;
        end else if (count_r != {W{1'b0}}) begin
            count_r <= count_r - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign done = (count_r == {W{1'b0}});
endmodule
`default_nettype wire

// File: testbench/latched_static_ram_2kx8_tb.sv
/* self-checking bench: controller against a behavioural memory.
   assumes 250 MHz clock and fast grade. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin fails++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module latched_static_ram_2kx8_tb;
    localparam [43:0] ADDRS = {11'h7ff, 11'h555, 11'h2aa, 11'h000};
    localparam [31:0] DATAS = {8'h00, 8'hff, 8'h3c, 8'ha5};
    reg core_clk = 1'b0;
    reg resetn = 1'b0;
    reg reqValid = 1'b0, reqWrite = 1'b0, reqBurst = 1'b0;
    reg [10:0] reqAddr = 11'h000;
    reg [7:0] reqWdata = 8'h00;
    wire reqReady, rspValid, chipOnN, storeN, outDriveN, memDataOeN;
    wire [7:0] rspRdata, memDataOut, memDataIn;
    wire [10:0] memAddr;
    integer fails = 0, totalChecks = 0, cycles = 0, lat, i;
    reg [7:0] rd;
    lsr_ctrl u_lsr_ctrl (.core_clk(core_clk), .resetn(resetn), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqBurst(reqBurst), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid),
        .rspRdata(rspRdata), .chipOnN(chipOnN), .storeN(storeN), .outDriveN(outDriveN), .memAddr(memAddr),
        .memDataOut(memDataOut), .memDataOeN(memDataOeN), .memDataIn(memDataIn));
    lsr_mem_model u_lsr_mem_model (.chipOnN(chipOnN), .storeN(storeN), .outDriveN(outDriveN),
        .memAddr(memAddr), .memDataOut(memDataOut), .memDataOeN(memDataOeN), .memDataIn(memDataIn));
    initial forever #2 core_clk = ~core_clk;
    task stopTest;
        begin
            $display("checks %0d mismatches %0d", totalChecks, fails);
            if (fails == 0 && totalChecks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails = fails + 1;
            stopTest;
        end
    end
    // ==========================================
    // one request, waits for its response
    task xfer(input w, input b, input [10:0] a, input [7:0] d);
        begin
            while (!reqReady) @(negedge core_clk);
            reqValid = 1'b1;
            reqWrite = w;
            reqBurst = b;
            reqAddr = a;
            reqWdata = d;
            @(negedge core_clk);
            reqValid = 1'b0;
            lat = 1;
            while (!rspValid && lat < 100) begin
                @(negedge core_clk);
                lat = lat + 1;
            end
            rd = rspRdata;
        end
    endtask
    task testReset;
        begin
            `CHK({reqReady, chipOnN, storeN, outDriveN, memDataOeN}, 5'h1f)
            $display("reset test done");
        end
    endtask
    task testWriteRead;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                xfer(1'b1, 1'b0, ADDRS[i*11 +: 11], DATAS[i*8 +: 8]);
                `CHK(lat, 46)
            end
            for (i = 0; i < 4; i = i + 1) begin
                xfer(1'b0, 1'b0, ADDRS[i*11 +: 11], 8'h00);
                `CHK(rd, DATAS[i*8 +: 8])
                `CHK(lat, 46)
            end
            $display("write read test done");
        end
    endtask
    task testBurst;
        begin
            for (i = 0; i < 3; i = i + 1) begin
                xfer(1'b1, i < 2, 11'h100 + i[10:0], DATAS[i*8 +: 8]);
                if (i == 0) `CHK(storeN, 1'b0)
            end
            for (i = 0; i < 3; i = i + 1) begin
                xfer(1'b0, 1'b0, 11'h100 + i[10:0], 8'h00);
                `CHK(rd, DATAS[i*8 +: 8])
            end
            $display("burst test done");
        end
    endtask
    task testOverwrite;
        begin
            xfer(1'b1, 1'b0, 11'h2aa, 8'h11);
            xfer(1'b0, 1'b0, 11'h2aa, 8'h00);
            `CHK(rd, 8'h11)
            xfer(1'b0, 1'b0, 11'h555, 8'h00);
            `CHK(rd, 8'hff)
            $display("overwrite test done");
        end
    endtask
    initial begin
        repeat (20) @(negedge core_clk);
        resetn = 1'b1;
        @(negedge core_clk);
        testReset;
        testWriteRead;
        testBurst;
        testOverwrite;
        stopTest;
    end
endmodule
`default_nettype wire

// File: testbench/lsr_ctrl_asserts.sv
/* pin timing checker for the static memory controller.
   sees only controller ports; bound at the foot. */
`timescale 1ns/1ps
`default_nettype none
module lsr_ctrl_asserts #(
    parameter SLOW_GRADE = 0,
    parameter ADDR_W = 11,
    parameter DATA_W = 8
) (
    input wire core_clk,
    input wire resetn,
    input wire chipOnN,
    input wire storeN,
    input wire outDriveN,
    input wire [ADDR_W-1:0] memAddr,
    input wire [DATA_W-1:0] memDataOut,
    input wire memDataOeN
);
    localparam LOW_MIN = SLOW_GRADE ? 50 : 30;
    localparam HIGH_MIN = SLOW_GRADE ? 20 : 13;
    localparam CYC_MIN = SLOW_GRADE ? 70 : 43;
    localparam SETUP_MIN = SLOW_GRADE ? 20 : 13;
    reg [7:0] lowCnt_r, highCnt_r, cycCnt_r, wLowCnt_r, dStabCnt_r;
    function [7:0] sat(input [7:0] v);
        sat = (v == 8'hff) ? v : v + 8'h01;
    endfunction
    // saturating so long idle gaps never wrap into a short pulse
    always @(posedge core_clk) begin
        if (!resetn) begin
            lowCnt_r <= 8'h00;
            highCnt_r <= 8'hff;
            cycCnt_r <= 8'hff;
            wLowCnt_r <= 8'h00;
            dStabCnt_r <= 8'h00;
        end else begin
            lowCnt_r <= chipOnN ? 8'h00 : sat(lowCnt_r);
            highCnt_r <= chipOnN ? sat(highCnt_r) : 8'h00;
            cycCnt_r <= $fell(chipOnN) ? 8'h01 : sat(cycCnt_r);
            wLowCnt_r <= storeN ? 8'h00 : sat(wLowCnt_r);
            dStabCnt_r <= (memDataOeN || !$stable(memDataOut)) ? 8'h00 : sat(dStabCnt_r);
        end
    end
    // ==========================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    AST_ADDR_HOLD: assert property ($fell(chipOnN) |-> $stable(memAddr)[*8])
        else $error("address moved in hold window");
    AST_READ_STORE: assert property (!chipOnN && !outDriveN |-> storeN)
        else $error("write strobe low in read");
    AST_NO_FIGHT: assert property (!memDataOeN |-> outDriveN)
        else $error("both sides may drive data");
    AST_DATA_SETUP: assert property ($rose(chipOnN) && !$past(storeN) |-> dStabCnt_r >= SETUP_MIN)
        else $error("write data setup short");
    AST_DATA_HOLD: assert property ($rose(chipOnN) && !$past(storeN) |-> (!memDataOeN && $stable(memDataOut))[*3])
        else $error("write data hold short");
    AST_CHIP_LOW: assert property ($rose(chipOnN) |-> lowCnt_r >= LOW_MIN)
        else $error("chip strobe low too short");
    AST_CHIP_HIGH: assert property ($fell(chipOnN) |-> highCnt_r >= HIGH_MIN)
        else $error("chip strobe high too short");
    AST_CYCLE: assert property ($fell(chipOnN) |-> cycCnt_r >= CYC_MIN)
        else $error("cycle time too short");
    AST_STORE_LOW: assert property ($rose(storeN) |-> wLowCnt_r >= LOW_MIN)
        else $error("write strobe low too short");
endmodule
bind lsr_ctrl lsr_ctrl_asserts #(.SLOW_GRADE(SLOW_GRADE), .ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_lsr_ctrl_asserts (
    .core_clk(core_clk), .resetn(resetn), .chipOnN(chipOnN), .storeN(storeN), .outDriveN(outDriveN),
    .memAddr(memAddr), .memDataOut(memDataOut), .memDataOeN(memDataOeN));
`default_nettype wire

// File: testbench/lsr_mem_model.sv
/* behavioural 2K x 8 latched-address static memory on the controller pins.
   assumes separate data lanes and active-low strobes from the controller. */
`timescale 1ns/1ps
`default_nettype none
module lsr_mem_model #(
    parameter ACC_NS = 116
) (
    input wire chipOnN,
    input wire storeN,
    input wire outDriveN,
    input wire [10:0] memAddr,
    input wire [7:0] memDataOut,
    input wire memDataOeN,
    output wire [7:0] memDataIn
);
    reg [7:0] mem [0:2047];
    reg [10:0] addrLat;
    reg armed = 1'b0;
    reg dataOk = 1'b0;
    wire drive = !chipOnN && !outDriveN && storeN;
    // released bus shows the inverse so a stale sample cannot match
    assign memDataIn = (drive && dataOk) ? mem[addrLat] : ~mem[addrLat];
    always @(negedge chipOnN) begin
        addrLat = memAddr;
        dataOk = 1'b0;
        #(ACC_NS) dataOk = 1'b1;
    end
    always @(negedge chipOnN or negedge storeN) begin
        if (!chipOnN && !storeN) armed <= 1'b1;
    end
    // armed flag makes the first rising strobe commit even when both rise together
    always @(posedge chipOnN or posedge storeN) begin
        if (armed) begin
            mem[addrLat] <= memDataOeN ? ~memDataOut : memDataOut;
            armed <= 1'b0;
        end
    end
endmodule
`default_nettype wire
